// ### shared/irs_pkg.sv
// Contract
// - bit 0 picks serial frame or parallel pins
// - transport bit leaves rtc, sci, smi alone
// - parallel mode frees two pins as irq15/irq14
// - bit 1 routes rtc irq frame or pin
// - bit 2 routes sci frame or pin
// - no serial frame on trickle power
// - bit 3 sets sci active level
// - bit 4 sets sci push-pull or open drain
// - bits 6:5 pick shared pin function
// - bit 5 overrides sci irq number choice
// - shared pin driver follows selected function
// - bit 7 routes smi slot 2 or pin
// - smi pin level and driver from gpio
// - forced change bits set by software only
// - step with drive select clears forced bit
// - media change flag ORs three terms
// - forced change bits 0,1; rest read zero
// - floppy rate mirror bit layout
// - serial port one fifo mirror layout
// - serial port two mirror, same layout
package irs_pkg;

  localparam int unsigned AW = 8;
  localparam int unsigned DW = 8;

  localparam logic [7:0] ADDR_ROUTE  = 8'hc0;
  localparam logic [7:0] ADDR_FORCE  = 8'hc1;
  localparam logic [7:0] ADDR_RATE   = 8'hc2;
  localparam logic [7:0] ADDR_SP1FCR = 8'hc3;
  localparam logic [7:0] ADDR_SP2FCR = 8'hc4;

  localparam logic [7:0] RST_ROUTE  = 8'h00;
  localparam logic [7:0] RST_FORCE  = 8'h03;
  localparam logic [7:0] RST_MIRROR = 8'h00;

  // interrupt_routing_control fields
  localparam int unsigned BIT_PARALLEL = 0;
  localparam int unsigned BIT_RTC_PIN  = 1;
  localparam int unsigned BIT_SCI_PIN  = 2;
  localparam int unsigned BIT_SCI_HIGH = 3;
  localparam int unsigned BIT_SCI_OD   = 4;
  localparam int unsigned BIT_SEL_LO   = 5;
  localparam int unsigned BIT_SEL_HI   = 6;
  localparam int unsigned BIT_SMI_PIN  = 7;

  // forced_disk_change fields
  localparam int unsigned BIT_FORCE0 = 0;
  localparam int unsigned BIT_FORCE1 = 1;
  localparam logic [7:0]  FORCE_MASK = 8'h03;

  // reserved bits of the mirrors read as zero
  localparam logic [7:0] RATE_MASK = 8'hdf;
  localparam logic [7:0] FCR_MASK  = 8'hcf;

  // synchronised pin vector
  localparam int unsigned NSYNC    = 5;
  localparam int unsigned SY_STEP  = 0;
  localparam int unsigned SY_DS0   = 1;
  localparam int unsigned SY_DS1   = 2;
  localparam int unsigned SY_CHG   = 3;
  localparam int unsigned SY_TRKL  = 4;
  // every filtered pin idles high, trickle included since it enters inverted;
  // a low idle here would gate the serial frame for several cycles after reset
  localparam logic [NSYNC-1:0] SYNC_IDLE = 5'h1f;

  typedef enum logic [1:0] {
    IRS_PIN_PME  = 2'b00,
    IRS_PIN_SCI  = 2'b01,
    IRS_PIN_IRQ9 = 2'b10,
    IRS_PIN_RSVD = 2'b11
  } irs_pin_func_type;

endpackage

// ### design/irs_regs.sv
// Our own choice: strobed register access.
`timescale 1ns/1ps
module irs_regs (
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       fdc_rate_wr,
  input  wire logic [7:0] fdc_rate_data,
  input  wire logic       sp1_fcr_wr,
  input  wire logic [7:0] sp1_fcr_data,
  input  wire logic       sp2_fcr_wr,
  input  wire logic [7:0] sp2_fcr_data,
  input  wire logic       rtc_irq_req,
  input  wire logic       sci_req,
  input  wire logic       smi_req,
  input  wire logic       power_event_req,
  input  wire logic       irq9_req,
  input  wire logic       irq14_req,
  input  wire logic       irq15_req,
  input  wire logic       gpio_smi_active_high,
  input  wire logic       gpio_smi_open_drain,
  input  wire logic       trickle_power_only,
  input  wire logic       head_step_strobe_n,
  input  wire logic       drive_zero_select_n,
  input  wire logic       drive_one_select_n,
  input  wire logic       media_changed_input_n,
  output logic            par_irq_mode,
  output logic            boot_rom_buf_en,
  output logic            serial_interrupt_pin_en,
  output logic            bus_clk_pin_en,
  output logic            frame_irq_en,
  output logic            frame_rtc_req,
  output logic            frame_sci_req,
  output logic            frame_smi_slot2_req,
  output logic            sci_isa_req,
  output logic            irq15_out,
  output logic            irq15_oe,
  output logic            irq14_out,
  output logic            irq14_oe,
  output logic            rtc_irq_pin_out,
  output logic            rtc_irq_pin_oe,
  output logic            shared_pin_out,
  output logic            shared_pin_oe,
  output logic            mgmt_interrupt_pin_n_out,
  output logic            mgmt_interrupt_pin_n_oe,
  output logic            media_changed_flag
);

  // pin driver: open drain can only pull low, so an active high
  // open-drain output pulls low while inactive
  function automatic logic [1:0] pin_drive(input logic active, input logic high, input logic od);
    logic level;
    level = active ? high : ~high;
    if (od) begin
      pin_drive = {1'b0, ~level};
    end else begin
      pin_drive = {level, 1'b1};
    end
  endfunction

  // registers
  logic [7:0] route_reg;
  logic [7:0] force_reg;
  logic [7:0] rate_mirror_reg;
  logic [7:0] sp1_mirror_reg;
  logic [7:0] sp2_mirror_reg;
  logic [7:0] route_next;
  logic [7:0] force_next;

  // three-stage pin synchronisers with agreement filter
  logic [irs_pkg::NSYNC-1:0] sync1_reg;
  logic [irs_pkg::NSYNC-1:0] sync2_reg;
  logic [irs_pkg::NSYNC-1:0] sync3_reg;
  logic [irs_pkg::NSYNC-1:0] pin_reg;
  wire  [irs_pkg::NSYNC-1:0] pin_raw;
  wire  [irs_pkg::NSYNC-1:0] pin_agree;
  wire  [irs_pkg::NSYNC-1:0] pin_next;

  assign pin_raw   = {~trickle_power_only, media_changed_input_n, drive_one_select_n,
                      drive_zero_select_n, head_step_strobe_n};
  assign pin_agree = ~(sync2_reg ^ sync3_reg);
  assign pin_next  = (pin_agree & sync3_reg) | (~pin_agree & pin_reg);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sync1_reg <= irs_pkg::SYNC_IDLE;
      sync2_reg <= irs_pkg::SYNC_IDLE;
      sync3_reg <= irs_pkg::SYNC_IDLE;
      pin_reg   <= irs_pkg::SYNC_IDLE;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pin_reg   <= pin_next;
    end
  end

  // asserted, active-high views of the filtered pins
  wire step_act;
  wire ds0_act;
  wire ds1_act;
  wire chg_act;
  wire on_trickle;

  assign step_act   = ~pin_reg[irs_pkg::SY_STEP];
  assign ds0_act    = ~pin_reg[irs_pkg::SY_DS0];
  assign ds1_act    = ~pin_reg[irs_pkg::SY_DS1];
  assign chg_act    = ~pin_reg[irs_pkg::SY_CHG];
  assign on_trickle = ~pin_reg[irs_pkg::SY_TRKL];

  // register decode
  wire hit_route;
  wire hit_force;
  wire hit_rate;
  wire hit_sp1;
  wire hit_sp2;
  wire wr_route;
  wire wr_force;

  assign hit_route = (reg_addr == irs_pkg::ADDR_ROUTE);
  assign hit_force = (reg_addr == irs_pkg::ADDR_FORCE);
  assign hit_rate  = (reg_addr == irs_pkg::ADDR_RATE);
  assign hit_sp1   = (reg_addr == irs_pkg::ADDR_SP1FCR);
  assign hit_sp2   = (reg_addr == irs_pkg::ADDR_SP2FCR);
  assign wr_route  = reg_wr & hit_route;
  assign wr_force  = reg_wr & hit_force;

  assign route_next = wr_route ? reg_wdata : route_reg;

  // forced disk change: software may only set; a step while the drive is
  // selected clears. a write of 1 in the same cycle wins over the clear.
  wire clr_force0;
  wire clr_force1;
  wire set_force0;
  wire set_force1;

  assign clr_force0 = step_act & ds0_act;
  assign clr_force1 = step_act & ds1_act;
  assign set_force0 = wr_force & reg_wdata[irs_pkg::BIT_FORCE0];
  assign set_force1 = wr_force & reg_wdata[irs_pkg::BIT_FORCE1];

  always_comb begin
    force_next = force_reg & irs_pkg::FORCE_MASK;
    if (clr_force0) begin
      force_next[irs_pkg::BIT_FORCE0] = 1'b0;
    end
    if (clr_force1) begin
      force_next[irs_pkg::BIT_FORCE1] = 1'b0;
    end
    if (set_force0) begin
      force_next[irs_pkg::BIT_FORCE0] = 1'b1;
    end
    if (set_force1) begin
      force_next[irs_pkg::BIT_FORCE1] = 1'b1;
    end
  end

  // read mux; unmapped addresses read zero
  wire [7:0] rd_mux;

  assign rd_mux = hit_route ? route_reg :
                  hit_force ? (force_reg & irs_pkg::FORCE_MASK) :
                  hit_rate  ? (rate_mirror_reg & irs_pkg::RATE_MASK) :
                  hit_sp1   ? (sp1_mirror_reg & irs_pkg::FCR_MASK) :
                  hit_sp2   ? (sp2_mirror_reg & irs_pkg::FCR_MASK) :
                  8'h00;

  // routing decode
  wire                      parallel;
  wire                      rtc_on_pin;
  wire                      sci_on_pin;
  wire                      smi_on_pin;
  wire                      frame_ok;
  irs_pkg::irs_pin_func_type pin_func;

  assign parallel   = route_reg[irs_pkg::BIT_PARALLEL];
  assign rtc_on_pin = route_reg[irs_pkg::BIT_RTC_PIN];
  assign sci_on_pin = route_reg[irs_pkg::BIT_SCI_PIN];
  assign smi_on_pin = route_reg[irs_pkg::BIT_SMI_PIN];
  assign frame_ok   = ~on_trickle;
  assign pin_func   = irs_pkg::irs_pin_func_type'(route_reg[irs_pkg::BIT_SEL_HI:irs_pkg::BIT_SEL_LO]);

  // rtc, sci and smi ignore the transport bit entirely
  wire frame_irq_next;
  wire frame_rtc_next;
  wire frame_sci_next;
  wire frame_smi_next;
  wire sci_isa_next;

  assign frame_irq_next = ~parallel & frame_ok;
  assign frame_rtc_next = ~rtc_on_pin & rtc_irq_req & frame_ok;
  assign frame_sci_next = ~sci_on_pin & sci_req & frame_ok;
  assign frame_smi_next = ~smi_on_pin & smi_req & frame_ok;

  // bit 5 set takes sci off the numbered irq line; the shared pin carries it only while bit 6 is clear
  assign sci_isa_next = sci_on_pin & ~route_reg[irs_pkg::BIT_SEL_LO] & sci_req;

  // pin drivers
  wire [1:0] irq15_drv;
  wire [1:0] irq14_drv;
  wire [1:0] rtc_drv;
  wire [1:0] smi_drv;
  wire [1:0] pme_drv;
  wire [1:0] sci_drv;
  wire [1:0] irq9_drv;
  logic [1:0] shared_drv;

  assign irq15_drv = parallel ? pin_drive(irq15_req, 1'b1, 1'b0) : 2'b00;
  assign irq14_drv = parallel ? pin_drive(irq14_req, 1'b1, 1'b0) : 2'b00;
  assign rtc_drv   = rtc_on_pin ? pin_drive(rtc_irq_req, 1'b1, 1'b0) : 2'b00;
  assign smi_drv   = smi_on_pin ?
                     pin_drive(smi_req, gpio_smi_active_high, gpio_smi_open_drain) : 2'b00;
  assign pme_drv   = pin_drive(power_event_req, 1'b0, 1'b1);
  assign sci_drv   = pin_drive(sci_req & sci_on_pin, route_reg[irs_pkg::BIT_SCI_HIGH],
                               route_reg[irs_pkg::BIT_SCI_OD]);
  assign irq9_drv  = pin_drive(irq9_req, 1'b1, 1'b0);

  // the reserved code leaves the shared pin undriven
  always_comb begin
    unique case (pin_func)
      irs_pkg::IRS_PIN_PME:  shared_drv = pme_drv;
      irs_pkg::IRS_PIN_SCI:  shared_drv = sci_drv;
      irs_pkg::IRS_PIN_IRQ9: shared_drv = irq9_drv;
      irs_pkg::IRS_PIN_RSVD: shared_drv = 2'b00;
    endcase
  end

  // disk change as seen by the floppy core
  wire media_next;

  assign media_next = (ds0_act & force_reg[irs_pkg::BIT_FORCE0]) |
                      (ds1_act & force_reg[irs_pkg::BIT_FORCE1]) | chg_act;

  // register file
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      route_reg       <= irs_pkg::RST_ROUTE;
      force_reg       <= irs_pkg::RST_FORCE;
      rate_mirror_reg <= irs_pkg::RST_MIRROR;
      sp1_mirror_reg  <= irs_pkg::RST_MIRROR;
      sp2_mirror_reg  <= irs_pkg::RST_MIRROR;
    end else begin
      route_reg <= route_next;
      force_reg <= force_next;
      if (fdc_rate_wr) begin
        rate_mirror_reg <= fdc_rate_data;
      end
      if (sp1_fcr_wr) begin
        sp1_mirror_reg <= sp1_fcr_data;
      end
      if (sp2_fcr_wr) begin
        sp2_mirror_reg <= sp2_fcr_data;
      end
    end
  end

  // read data stands only in the cycle after the read strobe
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // registered outputs; one cycle of latency keeps every pin glitch free
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      par_irq_mode            <= 1'b0;
      boot_rom_buf_en         <= 1'b1;
      serial_interrupt_pin_en <= 1'b1;
      bus_clk_pin_en          <= 1'b1;
      frame_irq_en            <= 1'b0;
      frame_rtc_req           <= 1'b0;
      frame_sci_req           <= 1'b0;
      frame_smi_slot2_req     <= 1'b0;
      sci_isa_req             <= 1'b0;
    end else begin
      par_irq_mode            <= parallel;
      boot_rom_buf_en         <= ~parallel;
      serial_interrupt_pin_en <= ~parallel;
      bus_clk_pin_en          <= ~parallel;
      frame_irq_en            <= frame_irq_next;
      frame_rtc_req           <= frame_rtc_next;
      frame_sci_req           <= frame_sci_next;
      frame_smi_slot2_req     <= frame_smi_next;
      sci_isa_req             <= sci_isa_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq15_out                <= 1'b0;
      irq15_oe                 <= 1'b0;
      irq14_out                <= 1'b0;
      irq14_oe                 <= 1'b0;
      rtc_irq_pin_out          <= 1'b0;
      rtc_irq_pin_oe           <= 1'b0;
      shared_pin_out           <= 1'b0;
      shared_pin_oe            <= 1'b0;
      mgmt_interrupt_pin_n_out <= 1'b0;
      mgmt_interrupt_pin_n_oe  <= 1'b0;
      media_changed_flag       <= 1'b0;
    end else begin
      {irq15_out, irq15_oe}                              <= irq15_drv;
      {irq14_out, irq14_oe}                              <= irq14_drv;
      {rtc_irq_pin_out, rtc_irq_pin_oe}                  <= rtc_drv;
      {shared_pin_out, shared_pin_oe}                    <= shared_drv;
      {mgmt_interrupt_pin_n_out, mgmt_interrupt_pin_n_oe} <= smi_drv;
      media_changed_flag                                 <= media_next;
    end
  end

endmodule

// ### verification/irs_regs_chk.sv
`timescale 1ns/1ps
module irs_regs_chk (
  input wire logic       clk_sys,
  input wire logic       srst,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       par_irq_mode,
  input wire logic       boot_rom_buf_en,
  input wire logic       frame_irq_en,
  input wire logic       irq15_req,
  input wire logic       irq15_out,
  input wire logic       irq15_oe,
  input wire logic       rtc_irq_req,
  input wire logic       rtc_irq_pin_out,
  input wire logic       rtc_irq_pin_oe,
  input wire logic       frame_rtc_req,
  input wire logic       sci_req,
  input wire logic       sci_isa_req,
  input wire logic       frame_sci_req,
  input wire logic       mgmt_interrupt_pin_n_out,
  input wire logic       mgmt_interrupt_pin_n_oe,
  input wire logic       frame_smi_slot2_req,
  input wire logic       gpio_smi_open_drain
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  property p_boot; boot_rom_buf_en == !par_irq_mode; endproperty
  a_boot: assert property (p_boot) else $error("boot buffer not off in parallel mode");
  property p_irq15; irq15_oe == par_irq_mode && irq15_out == (par_irq_mode && $past(irq15_req)); endproperty
  a_irq15: assert property (p_irq15) else $error("irq15 pin wrong");
  property p_frame; frame_irq_en |-> !par_irq_mode; endproperty
  a_frame: assert property (p_frame) else $error("frame active in parallel mode");
  property p_rtc; rtc_irq_pin_oe |-> !frame_rtc_req && rtc_irq_pin_out == $past(rtc_irq_req); endproperty
  a_rtc: assert property (p_rtc) else $error("rtc on pin and frame");
  property p_sci; sci_isa_req |-> !frame_sci_req && $past(sci_req); endproperty
  a_sci: assert property (p_sci) else $error("sci on pin and frame");
  property p_smi; mgmt_interrupt_pin_n_oe |-> !frame_smi_slot2_req; endproperty
  a_smi: assert property (p_smi) else $error("smi on pin and frame");
  property p_smi_od; $past(gpio_smi_open_drain) |-> !mgmt_interrupt_pin_n_out; endproperty
  a_smi_od: assert property (p_smi_od) else $error("open drain smi drives high");
  property p_force_rd; reg_rd && reg_addr == irs_pkg::ADDR_FORCE |=> reg_rdata[7:2] == 6'h00; endproperty
  a_force_rd: assert property (p_force_rd) else $error("forced change upper bits set");
  property p_rate_rd; reg_rd && reg_addr == irs_pkg::ADDR_RATE |=> !reg_rdata[5]; endproperty
  a_rate_rd: assert property (p_rate_rd) else $error("rate mirror bit 5 set");
  c_par: cover property (par_irq_mode && irq15_out);
  c_smi: cover property (mgmt_interrupt_pin_n_oe);
  c_force: cover property (reg_rd && reg_addr == irs_pkg::ADDR_FORCE);
endmodule

// ### verification/tb.sv
`timescale 1ns/1ps
module tb;
  logic       clk_sys = 1'b0;
  logic       srst = 1'b1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, s, e, rt = 8'h00, fm = 8'h03;
  logic [7:0] fdc_rate_data = 8'h00, sp1_fcr_data = 8'h00, sp2_fcr_data = 8'h00;
  logic [7:0] mir [3];
  logic       reg_wr = 1'b0, reg_rd = 1'b0, fdc_rate_wr = 1'b0, sp1_fcr_wr = 1'b0, sp2_fcr_wr = 1'b0;
  logic       rtc_irq_req = 1'b0, sci_req = 1'b0, smi_req = 1'b0, power_event_req = 1'b0, irq9_req = 1'b0;
  logic       irq14_req = 1'b0, irq15_req = 1'b0, gpio_smi_active_high = 1'b0, gpio_smi_open_drain = 1'b0;
  logic       trickle_power_only = 1'b0, head_step_strobe_n = 1'b1, drive_zero_select_n = 1'b1;
  logic       drive_one_select_n = 1'b1, media_changed_input_n = 1'b1;
  logic       par_irq_mode, boot_rom_buf_en, serial_interrupt_pin_en, bus_clk_pin_en, frame_irq_en;
  logic       frame_rtc_req, frame_sci_req, frame_smi_slot2_req, sci_isa_req, irq15_out, irq15_oe;
  logic       irq14_out, irq14_oe, rtc_irq_pin_out, rtc_irq_pin_oe, shared_pin_out, shared_pin_oe;
  logic       mgmt_interrupt_pin_n_out, mgmt_interrupt_pin_n_oe, media_changed_flag;
  int         n_mismatch = 0, comparisons = 0, cycles = 0;

  irs_regs i_dut (
    .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fdc_rate_wr(fdc_rate_wr), .fdc_rate_data(fdc_rate_data),
    .sp1_fcr_wr(sp1_fcr_wr), .sp1_fcr_data(sp1_fcr_data), .sp2_fcr_wr(sp2_fcr_wr), .sp2_fcr_data(sp2_fcr_data),
    .rtc_irq_req(rtc_irq_req), .sci_req(sci_req), .smi_req(smi_req), .power_event_req(power_event_req),
    .irq9_req(irq9_req), .irq14_req(irq14_req), .irq15_req(irq15_req),
    .gpio_smi_active_high(gpio_smi_active_high), .gpio_smi_open_drain(gpio_smi_open_drain),
    .trickle_power_only(trickle_power_only), .head_step_strobe_n(head_step_strobe_n),
    .drive_zero_select_n(drive_zero_select_n), .drive_one_select_n(drive_one_select_n),
    .media_changed_input_n(media_changed_input_n), .par_irq_mode(par_irq_mode), .boot_rom_buf_en(boot_rom_buf_en),
    .serial_interrupt_pin_en(serial_interrupt_pin_en), .bus_clk_pin_en(bus_clk_pin_en),
    .frame_irq_en(frame_irq_en), .frame_rtc_req(frame_rtc_req), .frame_sci_req(frame_sci_req),
    .frame_smi_slot2_req(frame_smi_slot2_req), .sci_isa_req(sci_isa_req), .irq15_out(irq15_out),
    .irq15_oe(irq15_oe), .irq14_out(irq14_out), .irq14_oe(irq14_oe), .rtc_irq_pin_out(rtc_irq_pin_out),
    .rtc_irq_pin_oe(rtc_irq_pin_oe), .shared_pin_out(shared_pin_out), .shared_pin_oe(shared_pin_oe),
    .mgmt_interrupt_pin_n_out(mgmt_interrupt_pin_n_out), .mgmt_interrupt_pin_n_oe(mgmt_interrupt_pin_n_oe),
    .media_changed_flag(media_changed_flag)
  );
  always #4 clk_sys = ~clk_sys;

  task automatic finish_test();
    if (n_mismatch == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // one gap cycle after each strobe keeps a strobe from being assigned twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    idle(1);
    reg_wr <= 1'b0;
    idle(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_rd <= 1'b1;
    reg_addr <= a;
    idle(1);
    reg_rd <= 1'b0;
    #1 chk("read", reg_rdata, exp);
    idle(1);
  endtask

  task automatic chk_route();
    logic t, lv, so, se, mo, me;
    t = trickle_power_only;
    lv = rt[3] ? (sci_req & rt[2]) : !(sci_req & rt[2]);
    so = rt[6:5] == 2'b01 ? !rt[4] & lv : rt[6:5] == 2'b10 & irq9_req;
    // active low open drain: the enable is on exactly while the event pulls the pin low
    se = rt[6:5] == 2'b00 ? power_event_req : rt[6:5] == 2'b01 ? !rt[4] | !lv : rt[6:5] == 2'b10;
    lv = gpio_smi_active_high ? smi_req : !smi_req;
    mo = rt[7] & !gpio_smi_open_drain & lv;
    me = rt[7] & (!gpio_smi_open_drain | !lv);
    s = {par_irq_mode, boot_rom_buf_en, serial_interrupt_pin_en, bus_clk_pin_en, frame_irq_en, frame_rtc_req,
      frame_sci_req, frame_smi_slot2_req};
    e = {rt[0], {3{!rt[0]}}, !rt[0] & !t, !rt[1] & rtc_irq_req & !t, !rt[2] & sci_req & !t, !rt[7] & smi_req & !t};
    chk("frame", s, e);
    s = {sci_isa_req, irq15_out, irq15_oe, irq14_out, irq14_oe, rtc_irq_pin_out, rtc_irq_pin_oe, 1'b0};
    e = {rt[2] & !rt[5] & sci_req, irq15_req & rt[0], rt[0], irq14_req & rt[0], rt[0], rtc_irq_req & rt[1], rt[1], 1'b0};
    chk("pins", s, e);
    s = {4'h0, shared_pin_out, shared_pin_oe, mgmt_interrupt_pin_n_out, mgmt_interrupt_pin_n_oe};
    chk("shared", s, {4'h0, so, se, mo, me});
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      finish_test();
    end
  end

  initial begin
    void'($urandom(32'hd0c5));
    idle(4);
    srst <= 1'b0;
    idle(1);
    for (int i = 0; i < 6; i++)
      rd(8'hc0 + 8'(i), i == 1 ? 8'h03 : 8'h00);
    for (int i = 0; i < 40; i++) begin
      rt = 8'($urandom);
      wr(irs_pkg::ADDR_ROUTE, rt);
      {rtc_irq_req, sci_req, smi_req, power_event_req, irq9_req, irq14_req, irq15_req,
        gpio_smi_active_high, gpio_smi_open_drain, trickle_power_only} <= 10'($urandom);
      idle(8);
      chk_route();
      rd(irs_pkg::ADDR_ROUTE, rt);
    end
    for (int i = 0; i < 6; i++) begin
      s = 8'($urandom);
      fdc_rate_wr <= 1'b1;
      sp1_fcr_wr <= 1'b1;
      sp2_fcr_wr <= 1'b1;
      fdc_rate_data <= s;
      sp1_fcr_data <= ~s;
      sp2_fcr_data <= s ^ 8'h5a;
      mir = '{s & 8'hdf, ~s & 8'hcf, (s ^ 8'h5a) & 8'hcf};
      idle(1);
      fdc_rate_wr <= 1'b0;
      sp1_fcr_wr <= 1'b0;
      sp2_fcr_wr <= 1'b0;
      // mirrors are read only, a register write must leave them alone
      wr(8'hc2 + 8'(i % 3), ~s);
      for (int j = 0; j < 3; j++)
        rd(8'hc2 + 8'(j), mir[j]);
    end
    for (int i = 0; i < 12; i++) begin
      {drive_one_select_n, drive_zero_select_n, media_changed_input_n} <= 3'($urandom);
      s = 8'($urandom);
      wr(irs_pkg::ADDR_FORCE, s);
      fm = fm | (s & 8'h03);
      idle(8);
      e = {7'h00, !drive_zero_select_n & fm[0] | !drive_one_select_n & fm[1] | !media_changed_input_n};
      chk("flag", {7'h00, media_changed_flag}, e);
      rd(irs_pkg::ADDR_FORCE, fm);
      head_step_strobe_n <= 1'b0;
      idle(8);
      fm = fm & {6'h00, drive_one_select_n, drive_zero_select_n};
      head_step_strobe_n <= 1'b1;
      idle(8);
      rd(irs_pkg::ADDR_FORCE, fm);
    end
    finish_test();
  end
endmodule

bind irs_regs irs_regs_chk i_chk (
  .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .par_irq_mode(par_irq_mode), .boot_rom_buf_en(boot_rom_buf_en), .frame_irq_en(frame_irq_en),
  .irq15_req(irq15_req), .irq15_out(irq15_out), .irq15_oe(irq15_oe), .rtc_irq_req(rtc_irq_req),
  .rtc_irq_pin_out(rtc_irq_pin_out), .rtc_irq_pin_oe(rtc_irq_pin_oe), .frame_rtc_req(frame_rtc_req),
  .sci_req(sci_req), .sci_isa_req(sci_isa_req), .frame_sci_req(frame_sci_req),
  .mgmt_interrupt_pin_n_out(mgmt_interrupt_pin_n_out), .mgmt_interrupt_pin_n_oe(mgmt_interrupt_pin_n_oe),
  .frame_smi_slot2_req(frame_smi_slot2_req), .gpio_smi_open_drain(gpio_smi_open_drain)
);
